// ===== clkgate_pkg.sv
/*
  Shared constants and carrier types for the clock output gating,
  power strobe and bus-select load logic.
  Assumes one internal clock (mclk, 100 MHz) derived from the reference.
*/
`default_nettype none

package clkgate_pkg;

  // ----------------------------------------------------------------
  // Configuration byte 6: enable bit positions of the request inputs
  // ----------------------------------------------------------------
  localparam int unsigned REQ_E_EN_BIT = 7;   // Pair 7 complement pin
  localparam int unsigned REQ_F_EN_BIT = 6;   // Pair 7 true pin
  localparam int unsigned REQ_G_EN_BIT = 5;   // Pair 11 complement pin
  localparam int unsigned REQ_H_EN_BIT = 4;   // Pair 11 true pin
  localparam logic [7:0]  CFG6_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Gated output indices
  // ----------------------------------------------------------------
  localparam int unsigned N_GATED   = 10;
  localparam int unsigned G_CPU0    = 0;  // Processor clock 0
  localparam int unsigned G_PROCESSOR_CLK_1    = 1;  // Processor clock 1, management clock
  localparam int unsigned G_SEL     = 2;  // Selectable pair: ref 8 or processor 2
  localparam int unsigned G_PCI     = 3;  // PCI clock
  localparam int unsigned G_SHARED  = 4;  // Serial ref 0 or alternate function
  localparam int unsigned G_SERIAL_REF_OUT_6    = 5;
  localparam int unsigned G_SRC7    = 6;
  localparam int unsigned G_SERIAL_REF_OUT_9    = 7;
  localparam int unsigned G_SERIAL_REF_OUT_10   = 8;
  localparam int unsigned G_SRC11   = 9;

  // ----------------------------------------------------------------
  // Timing and load counts
  // ----------------------------------------------------------------
  localparam int unsigned TICK_DIV_DEF  = 2;  // mclk cycles per output half period
  localparam int unsigned BUS_SELECT_DATA_BITS_DEF = 3;  // Bus-select bits in a serial load
  localparam int unsigned SYNC_STAGES   = 2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       test_mode;
    logic       debug_port_enable;
    logic       output_function_select;
    logic [2:0] freq_select;              // {c, b, a}
  } strap_type;

  localparam strap_type STRAP_RESET = 6'h00;

  typedef struct packed {
    logic       cpu_stop_n;
    logic       pci_stop_n;
    logic       power_good;
    logic [2:0] freq_select;
    logic       output_function_strap;
    logic       debug_port_enable;
    logic       test_mode_strap;
    logic       mgmt_entry;
    logic       request_e;
    logic       request_f;
    logic       request_g;
    logic       request_h;
  } pins_type;

  // Stops and requests idle high, power good idles low
  localparam pins_type PINS_RESET = 14'h300f;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_OFF,
    ST_LOAD,
    ST_MGMT
  } mode_type;

endpackage

`default_nettype wire

// ===== pin_sync.sv
/*
  Two-flop synchroniser for a vector of pins.
  Assumes each bit is an independent level; no bus coherence is implied.
*/
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int unsigned         WIDTH     = 1,
  parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_q;  // First stage, read only by second stage

  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RESET_VAL;
      synced <= RESET_VAL;
    end else begin
      meta_q <= pins;
      synced <= meta_q;
    end
  end

endmodule // pin_sync

`default_nettype wire

// ===== glitchless_gate.sv
/*
  One gated output clock built from a half-period tick.
  Assumes tick is a one-cycle pulse on mclk; run may change at any cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module glitchless_gate (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic tick,
  input  wire logic run,
  output logic      clk_q
);

  // ----------------------------------------------------------------
  // Output phase
  // ----------------------------------------------------------------
  // A high phase always completes, and a stopped clock parks low, so
  // stop and restart fall only on whole-cycle boundaries.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clk_q <= 1'b0;
    end else if (tick) begin
      clk_q <= clk_q ? 1'b0 : run;
    end
  end

endmodule // glitchless_gate

`default_nettype wire

// ===== clock_output_gating_power_strobe.sv
/*
  Output gating, power-good strap capture, power-down request and
  bus-select serial load of a multi-output clock generator.
  Assumes config byte 6 comes from register logic on mclk; all other
  inputs are pins and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none

// Operation
// - byte 6 bits 5,4 turn pair 11 into requests
// - request g gates ref 9, h gates ref 10
// - byte 6 bits 7,6 turn pair 7 into requests
// - request e gates ref 6, f gates ref 8
// - processor stop halts processor clocks
// - PCI stop halts PCI and serial refs
// - capture bus-select bit on PCI-stop rising edge
// - debug strap 0 selects serial ref 8
// - debug strap 1 selects processor clock 2
// - processor clock 1 runs in management mode
// - power good latches all six straps
// - after power good, pin is power-down request
// - straps captured once, except test mode
// - function strap picks serial or alternate function
module clock_output_gating_power_strobe
  import clkgate_pkg::*;
#(
  parameter int unsigned TICK_DIV  = TICK_DIV_DEF,
  parameter int unsigned BUS_SELECT_DATA_BITS = BUS_SELECT_DATA_BITS_DEF
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 cpu_stop_n,
  input  wire logic                 pci_stop_n,
  input  wire logic                 power_good,
  input  wire logic                 freq_select_a,
  input  wire logic                 freq_select_b,
  input  wire logic                 freq_select_c,
  input  wire logic                 output_function_strap,
  input  wire logic                 debug_port_enable,
  input  wire logic                 test_mode_strap,
  input  wire logic                 mgmt_entry,
  input  wire logic                 request_e,
  input  wire logic                 request_f,
  input  wire logic                 request_g,
  input  wire logic                 request_h,
  input  wire logic [7:0]           config_byte6,
  output logic      [N_GATED-1:0]   clk_out,
  output logic      [1:0]           pair7_oe,
  output logic      [1:0]           pair11_oe,
  output logic                      sel_pair_is_cpu,
  output logic                      shared_alt_function,
  output strap_type                 straps,
  output logic                      straps_valid,
  output logic                      power_down,
  output logic                      management_mode,
  output logic      [BUS_SELECT_DATA_BITS-1:0] bus_select_data,
  output logic                      bus_select_valid
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  pins_type pins_raw;   // Raw pin levels
  pins_type pins_s;     // Synchronised levels

  assign pins_raw = '{cpu_stop_n, pci_stop_n, power_good,
                      {freq_select_c, freq_select_b, freq_select_a},
                      output_function_strap, debug_port_enable,
                      test_mode_strap, mgmt_entry,
                      request_e, request_f, request_g, request_h};

  pin_sync #(
    .WIDTH     ($bits(pins_type)),
    .RESET_VAL (PINS_RESET)
  ) u_sync (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .pins   (pins_raw),
    .synced (pins_s)
  );

  // ----------------------------------------------------------------
  // Output tick divider
  // ----------------------------------------------------------------
  localparam int unsigned TW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_DIV - 1);

  logic [TW-1:0] div_q;   // Divider count
  logic          tick;    // Half-period enable

  assign tick = (div_q == TICK_LAST);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + TW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Strap capture and power-down request
  // ----------------------------------------------------------------
  // Capture is one-shot: the first high power good seen freezes the
  // straps; only test mode lets frequency selects follow the pins.
  logic capture;   // First high sample of power good
  assign capture = pins_s.power_good && !straps_valid;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      straps       <= STRAP_RESET;
      straps_valid <= 1'b0;
    end else if (capture) begin
      straps       <= '{pins_s.test_mode_strap, pins_s.debug_port_enable,
                        pins_s.output_function_strap, pins_s.freq_select};
      straps_valid <= 1'b1;
    end else if (straps.test_mode) begin
      straps.freq_select <= pins_s.freq_select;
    end
  end

  // After capture the same pin is a live active-low power-down request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      power_down <= 1'b0;
    end else begin
      power_down <= straps_valid && !pins_s.power_good;
    end
  end

  // ----------------------------------------------------------------
  // Mode state and bus-select serial load
  // ----------------------------------------------------------------
  localparam int unsigned CW = (BUS_SELECT_DATA_BITS > 1) ? $clog2(BUS_SELECT_DATA_BITS) : 1;
  localparam logic [CW-1:0] BUS_SELECT_DATA_LAST = CW'(BUS_SELECT_DATA_BITS - 1);

  mode_type      mode_q;       // Current mode
  mode_type      mode_d;       // Next mode
  logic          pci_prev_q;   // Previous synced PCI-stop level
  logic          pci_rise;     // Rising edge of PCI-stop
  logic [CW-1:0] bit_cnt_q;    // Bits loaded so far

  assign pci_rise = pins_s.pci_stop_n && !pci_prev_q;

  // Next mode
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      ST_RUN: begin
        if (power_down) mode_d = ST_OFF;
      end
      ST_OFF: begin
        if (pins_s.mgmt_entry) mode_d = ST_LOAD;
        else if (!power_down) mode_d = ST_RUN;
      end
      ST_LOAD: begin
        if (!pins_s.mgmt_entry) mode_d = ST_OFF;
        else if (pci_rise && bit_cnt_q == BUS_SELECT_DATA_LAST) mode_d = ST_MGMT;
      end
      ST_MGMT: begin
        if (!pins_s.mgmt_entry) mode_d = ST_OFF;
      end
      default: mode_d = ST_OFF;
    endcase
  end

  // State, edge history, serial shift
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q           <= ST_RUN;
      pci_prev_q       <= 1'b1;
      bit_cnt_q        <= '0;
      bus_select_data  <= '0;
      bus_select_valid <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      pci_prev_q <= pins_s.pci_stop_n;
      if (mode_q == ST_OFF) begin
        bit_cnt_q <= '0;
      end else if (mode_q == ST_LOAD && pci_rise) begin
        bus_select_data <= {bus_select_data[BUS_SELECT_DATA_BITS-2:0],
                            pins_s.cpu_stop_n};
        bit_cnt_q       <= bit_cnt_q + CW'(1);
        if (bit_cnt_q == BUS_SELECT_DATA_LAST) bus_select_valid <= 1'b1;
      end
    end
  end

  assign management_mode = (mode_q == ST_MGMT);

  // ----------------------------------------------------------------
  // Run decisions
  // ----------------------------------------------------------------
  // In load mode the stop pins carry data and strobe, so they never act as stops.
  logic normal;          // Clocks allowed
  logic run_cpu;         // Processor group may run
  logic run_src;         // PCI and serial group may run
  logic req_e_on;        // Request input e enabled
  logic req_f_on;
  logic req_g_on;
  logic req_h_on;
  logic [N_GATED-1:0] run;

  assign normal   = (mode_q == ST_RUN);
  assign run_cpu  = normal && pins_s.cpu_stop_n;
  assign run_src  = normal && pins_s.pci_stop_n;
  assign req_e_on = config_byte6[REQ_E_EN_BIT];
  assign req_f_on = config_byte6[REQ_F_EN_BIT];
  assign req_g_on = config_byte6[REQ_G_EN_BIT];
  assign req_h_on = config_byte6[REQ_H_EN_BIT];

  assign sel_pair_is_cpu     = straps.debug_port_enable;
  assign shared_alt_function = straps.output_function_select;

  assign run[G_CPU0]   = run_cpu;
  assign run[G_PROCESSOR_CLK_1]   = run_cpu || management_mode;
  assign run[G_SEL]    = sel_pair_is_cpu ? run_cpu
                       : (run_src && !(req_f_on && pins_s.request_f));
  assign run[G_PCI]    = run_src;
  // Alternate fixed function is not a serial reference and ignores PCI stop
  assign run[G_SHARED] = shared_alt_function ? normal : run_src;
  assign run[G_SERIAL_REF_OUT_6]   = run_src && !(req_e_on && pins_s.request_e);
  assign run[G_SRC7]   = run_src && !(req_e_on || req_f_on);
  assign run[G_SERIAL_REF_OUT_9]   = run_src && !(req_g_on && pins_s.request_g);
  assign run[G_SERIAL_REF_OUT_10]  = run_src && !(req_h_on && pins_s.request_h);
  assign run[G_SRC11]  = run_src && !(req_g_on || req_h_on);

  // Shared pins stop driving while they serve as request inputs
  assign pair7_oe  = {!req_e_on, !req_f_on};
  assign pair11_oe = {!req_g_on, !req_h_on};

  // ----------------------------------------------------------------
  // Gated outputs
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N_GATED; i++) begin : g_out
    glitchless_gate u_gate (
      .mclk  (mclk),
      .rst_b (rst_b),
      .tick  (tick),
      .run   (run[i]),
      .clk_q (clk_out[i])
    );
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_loading;
    mode_q == ST_LOAD && pins_s.mgmt_entry;
  endsequence

  sequence s_pci_rise;
    pci_rise;
  endsequence

  a_req_g_gate: assert property (req_g_on && pins_s.request_g |-> !run[G_SERIAL_REF_OUT_9])
    else $error("request g did not stop ref 9");
  a_req_h_gate: assert property (req_h_on && pins_s.request_h |-> !run[G_SERIAL_REF_OUT_10])
    else $error("request h did not stop ref 10");
  a_req_e_gate: assert property (req_e_on && pins_s.request_e |-> !run[G_SERIAL_REF_OUT_6])
    else $error("request e did not stop ref 6");
  a_pair11_oe: assert property (req_g_on |-> !pair11_oe[1] && !run[G_SRC11])
    else $error("pair 11 still driven as clock");
  a_pair7_oe: assert property (req_f_on |-> !pair7_oe[0] && !run[G_SRC7])
    else $error("pair 7 still driven as clock");
  a_cpu_stop: assert property (!pins_s.cpu_stop_n && !management_mode
                               |-> !run[G_CPU0] && !run[G_PROCESSOR_CLK_1])
    else $error("processor clock runs while stopped");
  a_pci_stop: assert property (!pins_s.pci_stop_n |-> !run[G_PCI] && !run[G_SERIAL_REF_OUT_9])
    else $error("PCI or serial clock runs while stopped");
  a_bus_select_data_shift: assert property (s_loading ##0 s_pci_rise |=>
                                 bus_select_data[0] == $past(pins_s.cpu_stop_n))
    else $error("bus-select bit not captured");
  a_mgmt_clk1: assert property (management_mode && tick && !clk_out[G_PROCESSOR_CLK_1]
                                |=> clk_out[G_PROCESSOR_CLK_1])
    else $error("management clock not running");
  a_strap_hold: assert property (straps_valid && !straps.test_mode
                                 |=> $stable(straps))
    else $error("straps changed after capture");
  a_strap_take: assert property (capture |=> straps.freq_select
                                 == $past(pins_s.freq_select) && straps_valid)
    else $error("straps not latched on power good");
  a_pd_live: assert property (straps_valid && !pins_s.power_good |=> power_down)
    else $error("power-down request not seen");
  a_sel_mux: assert property (straps_valid && !straps.debug_port_enable && normal
                              && !pins_s.cpu_stop_n && pins_s.pci_stop_n
                              && !req_f_on |-> run[G_SEL])
    else $error("selectable pair not serial ref 8");
  a_gate_edge: assert property ($changed(clk_out) |-> $past(tick))
    else $error("output edge off the tick grid");

endmodule // clock_output_gating_power_strobe

`default_nettype wire

// ===== pm_partner.sv
/*
  Behavioural model of the chipset power-management side: power-good
  strobe, stop pins, management-mode entry and the serial bus-select load.
  Assumes the bench calls its tasks one at a time, in the mclk domain.
*/
`timescale 1ns/100ps
`default_nettype none

module pm_partner (
  input  wire logic mclk,
  output logic      cpu_stop_n,
  output logic      pci_stop_n,
  output logic      power_good,
  output logic      mgmt_entry
);
  // Idle levels: stops released, power not yet good, no entry request
  initial begin
    cpu_stop_n = 1'b1;
    pci_stop_n = 1'b1;
    power_good = 1'b0;
    mgmt_entry = 1'b0;
  end

  // ----------------------------------------------------------------
  // Pin sequences
  // ----------------------------------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Raise or drop the strobe, then give the sync chain time to see it
  task automatic set_power(input logic lvl);
    @(posedge mclk);
    power_good <= lvl;
    wait_cyc(8);
  endtask

  // Both stop pins change together, off the sampling edge
  task automatic set_stops(input logic cpu, input logic pci);
    @(posedge mclk);
    cpu_stop_n <= cpu;
    pci_stop_n <= pci;
  endtask

  // Entry request, then one bit per PCI-stop pulse, first bit first
  task automatic load_bus_select_data(input logic [2:0] bits);
    @(posedge mclk);
    mgmt_entry <= 1'b1;
    wait_cyc(6);
    for (int i = 2; i >= 0; i--) begin
      @(posedge mclk);
      cpu_stop_n <= bits[i];
      pci_stop_n <= 1'b0;
      wait_cyc(4);
      @(posedge mclk);
      pci_stop_n <= 1'b1;
      wait_cyc(4);            // Data held well past the rising strobe
    end
    @(posedge mclk);
    cpu_stop_n <= ~bits[0];   // Released line does not keep the last bit
    wait_cyc(6);
  endtask
endmodule // pm_partner

`default_nettype wire

// ===== clock_output_gating_power_strobe_bench.sv
/*
  Self-checking bench: straps, output enables, stop and request gating,
  power-down, bus-select load and whole-cycle gating of the outputs.
  Assumes the design's default half period and bus-select length.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end

module clock_output_gating_power_strobe_bench;
  import clkgate_pkg::*;

  localparam int unsigned TD = TICK_DIV_DEF;   // Half period of a gated output
  localparam int unsigned BB = BUS_SELECT_DATA_BITS_DEF;  // Bus-select bits per load

  logic                 mclk, rst_b;
  logic                 cpu_stop_n, pci_stop_n, power_good, mgmt_entry;
  logic [2:0]           freq_select;      // {c, b, a}
  logic                 func_strap, debug_strap, test_strap;
  logic [3:0]           req;              // {e, f, g, h}, low = wanted
  logic [7:0]           cfg6;
  logic [N_GATED-1:0]   clk_out;
  logic [1:0]           pair7_oe, pair11_oe;
  logic                 sel_pair_is_cpu, shared_alt_function;
  strap_type            straps;
  logic                 straps_valid, power_down, management_mode;
  logic [BB-1:0]        bus_select_data;
  logic                 bus_select_valid;
  int                   n_errors = 0;
  int                   n_tests = 0;
  int unsigned          hi_len [N_GATED];

  // ----------------------------------------------------------------
  // Clock, inputs at time zero, instances
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    freq_select = 3'h0;
    {func_strap, debug_strap, test_strap} = 3'h0;
    req = 4'h0;
    cfg6 = 8'h00;
  end
  always #5 mclk = ~mclk;

  pm_partner pm_partner_inst (
    .mclk(mclk), .cpu_stop_n(cpu_stop_n), .pci_stop_n(pci_stop_n),
    .power_good(power_good), .mgmt_entry(mgmt_entry));

  clock_output_gating_power_strobe #(.TICK_DIV(TD), .BUS_SELECT_DATA_BITS(BB))
    clock_output_gating_power_strobe_inst (
    .mclk(mclk), .rst_b(rst_b), .cpu_stop_n(cpu_stop_n), .pci_stop_n(pci_stop_n),
    .power_good(power_good), .freq_select_a(freq_select[0]),
    .freq_select_b(freq_select[1]), .freq_select_c(freq_select[2]),
    .output_function_strap(func_strap), .debug_port_enable(debug_strap),
    .test_mode_strap(test_strap), .mgmt_entry(mgmt_entry),
    .request_e(req[3]), .request_f(req[2]), .request_g(req[1]), .request_h(req[0]),
    .config_byte6(cfg6), .clk_out(clk_out), .pair7_oe(pair7_oe),
    .pair11_oe(pair11_oe), .sel_pair_is_cpu(sel_pair_is_cpu),
    .shared_alt_function(shared_alt_function), .straps(straps),
    .straps_valid(straps_valid), .power_down(power_down),
    .management_mode(management_mode), .bus_select_data(bus_select_data),
    .bus_select_valid(bus_select_valid));

  // Every high phase must be exactly one half period; a cut pulse is a glitch
  always @(posedge mclk) begin
    for (int k = 0; k < N_GATED; k++) begin
      if (!rst_b) hi_len[k] = 0;
      else if (clk_out[k]) hi_len[k]++;
      else begin
        if (hi_len[k] != 0) `CHK("high phase", TD, hi_len[k])
        hi_len[k] = 0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Let gating settle, then see whether the output still toggles
  task automatic check_run(input int idx, input logic exp);
    logic first;
    logic moved;
    repeat (12) @(posedge mclk);
    #1;
    first = clk_out[idx];
    moved = 1'b0;
    repeat (16) begin
      @(posedge mclk);
      #1;
      if (clk_out[idx] !== first) moved = 1'b1;
    end
    `CHK($sformatf("clk_out[%0d] running", idx), exp, moved)
  endtask

  // Reset held three cycles; straps set long before power good rises
  task automatic reset_and_power(input logic dbg, input logic fn, input logic [2:0] fs);
    @(posedge mclk);
    rst_b <= 1'b0;
    debug_strap <= dbg;
    func_strap <= fn;
    freq_select <= fs;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    pm_partner_inst.wait_cyc(6);
    pm_partner_inst.set_power(1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_output_enables();
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      cfg6 <= {i[3:0], 4'h0};
      @(posedge mclk);
      #1;
      `CHK("pair7_oe", ~i[3:2], pair7_oe)
      `CHK("pair11_oe", ~i[1:0], pair11_oe)
    end
    @(posedge mclk);
    cfg6 <= 8'h00;
  endtask

  task automatic t_straps();
    `CHK("straps", strap_type'({3'b001, 3'b101}), straps)
    `CHK("straps_valid", 1'b1, straps_valid)
    `CHK("sel_pair_is_cpu", 1'b0, sel_pair_is_cpu)
    `CHK("shared_alt_function", 1'b1, shared_alt_function)
    @(posedge mclk);
    freq_select <= 3'b010;
    func_strap <= 1'b0;
    pm_partner_inst.wait_cyc(8);
    `CHK("straps held", strap_type'({3'b001, 3'b101}), straps)
  endtask

  task automatic t_stops();
    pm_partner_inst.set_stops(1'b0, 1'b1);
    check_run(G_CPU0, 1'b0);
    check_run(G_PROCESSOR_CLK_1, 1'b0);
    check_run(G_PCI, 1'b1);
    check_run(G_SEL, 1'b1);
    check_run(G_SRC11, 1'b1);
    pm_partner_inst.set_stops(1'b1, 1'b0);
    check_run(G_PCI, 1'b0);
    check_run(G_SERIAL_REF_OUT_6, 1'b0);
    check_run(G_SEL, 1'b0);
    check_run(G_SHARED, 1'b1);
    check_run(G_CPU0, 1'b1);
    pm_partner_inst.set_stops(1'b1, 1'b1);
  endtask

  // One request at a time withdrawn; only its own target may stop
  task automatic t_requests();
    int tgt [4];
    tgt = '{G_SERIAL_REF_OUT_6, G_SEL, G_SERIAL_REF_OUT_9, G_SERIAL_REF_OUT_10};
    @(posedge mclk);
    cfg6 <= 8'hf0;
    check_run(G_SRC7, 1'b0);
    check_run(G_SRC11, 1'b0);
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk);
      req <= 4'b1000 >> r;
      for (int t = 0; t < 4; t++) check_run(tgt[t], t != r);
    end
    @(posedge mclk);
    req <= 4'h0;
    cfg6 <= 8'h00;
  endtask

  task automatic t_power_down_load();
    pm_partner_inst.set_power(1'b0);
    `CHK("power_down", 1'b1, power_down)
    check_run(G_CPU0, 1'b0);
    pm_partner_inst.load_bus_select_data(3'b110);
    `CHK("bus_select_data", 3'b110, bus_select_data)
    `CHK("bus_select_valid", 1'b1, bus_select_valid)
    `CHK("management_mode", 1'b1, management_mode)
    check_run(G_PROCESSOR_CLK_1, 1'b1);
    check_run(G_PCI, 1'b0);
  endtask

  // Test mode latched here, so the frequency selects keep following the pins
  task automatic t_debug_strap();
    @(posedge mclk);
    test_strap <= 1'b1;
    reset_and_power(1'b1, 1'b0, 3'b011);
    `CHK("sel_pair_is_cpu", 1'b1, sel_pair_is_cpu)
    `CHK("shared_alt_function", 1'b0, shared_alt_function)
    `CHK("straps", strap_type'({3'b110, 3'b011}), straps)
    @(posedge mclk);
    freq_select <= 3'b100;
    pm_partner_inst.wait_cyc(4);
    `CHK("straps test mode", strap_type'({3'b110, 3'b100}), straps)
    pm_partner_inst.set_stops(1'b0, 1'b1);
    check_run(G_SEL, 1'b0);
    check_run(G_SHARED, 1'b1);
    pm_partner_inst.set_stops(1'b1, 1'b0);
    check_run(G_SEL, 1'b1);
    check_run(G_SHARED, 1'b0);
    pm_partner_inst.set_stops(1'b1, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    reset_and_power(1'b0, 1'b1, 3'b101);
    t_output_enables();
    t_straps();
    t_stops();
    t_requests();
    t_power_down_load();
    t_debug_strap();
    report_and_stop();
  end

  // Whole sequence needs about 1200 cycles; this is far beyond it
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
endmodule // clock_output_gating_power_strobe_bench

`default_nettype wire
